// file: src/brs_sequencer.sv
// brown-out reset sequencer with reset-time register defaults
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module brs_sequencer
   import brs_pkg::*;
#(
   parameter int unsigned START_CYCLES = BRS_START_CYC
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // analog comparator and pins, asynchronous
   input  wire logic       supply_low,
   input  wire logic       brownout_enable_bit,
   input  wire logic       master_clear_pin_n,
   // core events, same clock
   input  wire logic       wdt_timeout,
   input  wire logic       sleep_enter,
   input  wire logic       global_interrupt_disable,
   input  wire logic [7:0] wake_int_set,
   input  wire logic [7:0] wake_pf1_set,
   input  wire logic [7:0] wake_pf2_set,
   // external bus controller
   input  wire logic       ext_bus_mode,
   input  wire logic [7:0] bus_dir_h,
   input  wire logic [7:0] bus_dir_j,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // reset and port outputs
   output logic            chip_reset,
   output logic            pc_load_vector,
   output logic      [7:0] port_h_dir,
   output logic      [7:0] port_j_dir,
   output logic      [6:0] timer3_control,
   output logic            brownout_flag
);
   // whole state of the sequencer
   typedef struct packed {
      brs_state_t st;         // sequencer state
      logic       sup_s1;     // supply sync, first stage
      logic       sup_s2;     // supply sync, second stage
      logic       en_s1;      // enable sync, first stage
      logic       en_s2;      // enable sync, second stage
      logic       clr_s1;     // clear pin sync, first stage
      logic       clr_s2;     // clear pin sync, second stage
      logic [7:0] dir_h;      // port h direction register
      logic [7:0] dir_j;      // port j direction register
      logic [6:0] tmr3;       // timer3 control, top bit absent
      logic [7:0] int_stat;   // interrupt status
      logic [7:0] pflag1;     // peripheral flags one
      logic [7:0] pflag2;     // peripheral flags two
      logic       bor;        // sticky brown-out cause
      logic [7:0] rdata;      // read data, one cycle
      logic       reset;      // chip reset output
      logic       vec;        // vector load pulse
      logic [7:0] h_out;      // effective port h direction
      logic [7:0] j_out;      // effective port j direction
   } brs_st_t;

   // power-on value; synchronisers start as supply good, clear released
   localparam brs_st_t RST_VAL = '{
      st: BRS_START, sup_s1: 1'b0, sup_s2: 1'b0, en_s1: 1'b0, en_s2: 1'b0,
      clr_s1: 1'b1, clr_s2: 1'b1, dir_h: BRS_RST_DIR, dir_j: BRS_RST_DIR,
      tmr3: BRS_RST_TMR3, int_stat: BRS_RST_FLAGS, pflag1: BRS_RST_FLAGS,
      pflag2: BRS_RST_FLAGS, bor: 1'b0, rdata: 8'h00, reset: 1'b1, vec: 1'b0,
      h_out: BRS_RST_DIR, j_out: BRS_RST_DIR};

   brs_st_t q_r;     // registered state
   brs_st_t q_nxt;   // next state

   brs_tmr_if tmr_if ();

   logic bor_low;     // qualified under-voltage
   logic hold_req;    // any level that holds reset
   logic wake_any;    // some wake source present
   logic wr_hit;      // write strobe to a live register

   // flag register update: software value, hardware set wins
   function automatic logic [7:0] flag_upd(input logic [7:0] cur, input logic [7:0] set,
                                            input logic hit, input logic [7:0] wd);
      logic [7:0] base;
      base = hit ? wd : cur;
      return base | set;
   endfunction

   // start-up delay counter
   brs_start_timer #(
      .START_CYCLES (START_CYCLES)
   ) u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tmr      (tmr_if.tmr)
   );

   // qualification of reset causes from synchronised levels
   always_comb begin
      bor_low  = q_r.en_s2 && q_r.sup_s2;
      hold_req = bor_low || !q_r.clr_s2;
      wake_any = (wake_int_set != 8'h00) || (wake_pf1_set != 8'h00) || (wake_pf2_set != 8'h00);
      wr_hit   = reg_wr && !q_r.reset;
   end

   // timer control: held at zero outside start-up, so a watchdog
   // restart from run waits the full delay as well
   always_comb begin
      tmr_if.clear = (q_r.st != BRS_START) || hold_req;
      tmr_if.run   = (q_r.st == BRS_START) && !hold_req;
   end

   // next-state logic for sequencer, registers and outputs
   always_comb begin
      q_nxt = q_r;
      // two-stage synchronisers, first stage read only here
      q_nxt.sup_s1  = supply_low;
      q_nxt.sup_s2  = q_r.sup_s1;
      q_nxt.en_s1   = brownout_enable_bit;
      q_nxt.en_s2   = q_r.en_s1;
      q_nxt.clr_s1  = master_clear_pin_n;
      q_nxt.clr_s2  = q_r.clr_s1;
      q_nxt.vec     = 1'b0;

      // sequencer
      unique case (q_r.st)
         BRS_HOLD: begin
            // stay in reset until every holding level is gone
            if (!hold_req) begin
               q_nxt.st = BRS_START;
            end
         end
         BRS_START: begin
            if (hold_req) begin
               q_nxt.st = BRS_HOLD;
            end else if (tmr_if.done) begin
               q_nxt.st = BRS_RUN;
            end
         end
         BRS_RUN: begin
            if (hold_req) begin
               q_nxt.st = BRS_HOLD;
            end else if (wdt_timeout) begin
               q_nxt.st = BRS_START;
            end else if (sleep_enter) begin
               q_nxt.st = BRS_SLEEP;
            end
         end
         BRS_SLEEP: begin
            if (hold_req) begin
               q_nxt.st = BRS_HOLD;
            end else if (wdt_timeout || wake_any) begin
               // wake keeps every register as it was except the flags that the wake source sets
               q_nxt.st  = BRS_RUN;
               q_nxt.vec = (wake_int_set != 8'h00) && !global_interrupt_disable;
            end
         end
      endcase

      // sticky brown-out cause, set wins over the clear
      if (wr_hit && reg_addr == BRS_OFS_STATUS && reg_wdata[BRS_ST_BOR_BIT]) begin
         q_nxt.bor = 1'b0;
      end
      if (bor_low && q_r.st != BRS_HOLD) begin
         q_nxt.bor = 1'b1;
      end

      // software writes, ignored while the chip is in reset
      if (wr_hit && reg_addr == BRS_OFS_DIR_H) begin
         q_nxt.dir_h = reg_wdata;
      end
      if (wr_hit && reg_addr == BRS_OFS_DIR_J) begin
         q_nxt.dir_j = reg_wdata;
      end
      if (wr_hit && reg_addr == BRS_OFS_TMR3_CTL) begin
         q_nxt.tmr3 = reg_wdata[6:0];
      end
      // wake sources mark themselves in the flag registers
      q_nxt.int_stat = flag_upd(q_r.int_stat, wake_int_set, wr_hit && reg_addr == BRS_OFS_INT_STAT,
                                reg_wdata);
      q_nxt.pflag1   = flag_upd(q_r.pflag1, wake_pf1_set, wr_hit && reg_addr == BRS_OFS_PFLAG1,
                                reg_wdata);
      q_nxt.pflag2   = flag_upd(q_r.pflag2, wake_pf2_set, wr_hit && reg_addr == BRS_OFS_PFLAG2,
                                reg_wdata);

      // any device reset returns the direction registers to inputs; in bus mode the pins still follow the bus controller
      if (q_nxt.st == BRS_HOLD || q_nxt.st == BRS_START) begin
         q_nxt.dir_h = BRS_RST_DIR;
         q_nxt.dir_j = BRS_RST_DIR;
         q_nxt.tmr3  = BRS_RST_TMR3;
      end
      q_nxt.reset = (q_nxt.st == BRS_HOLD) || (q_nxt.st == BRS_START);

      // bus modes drive the pins from the bus controller instead
      q_nxt.h_out = ext_bus_mode ? bus_dir_h : q_nxt.dir_h;
      q_nxt.j_out = ext_bus_mode ? bus_dir_j : q_nxt.dir_j;

      // read data stand for one cycle only; unmapped reads give zero
      q_nxt.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            BRS_OFS_DIR_H:    q_nxt.rdata = q_r.dir_h;
            BRS_OFS_DIR_J:    q_nxt.rdata = q_r.dir_j;
            BRS_OFS_TMR3_CTL: q_nxt.rdata = {1'b0, q_r.tmr3};
            BRS_OFS_INT_STAT: q_nxt.rdata = q_r.int_stat;
            BRS_OFS_PFLAG1:   q_nxt.rdata = q_r.pflag1;
            BRS_OFS_PFLAG2:   q_nxt.rdata = q_r.pflag2;
            BRS_OFS_STATUS: begin
               q_nxt.rdata[BRS_ST_HOLD_BIT]  = q_r.st == BRS_HOLD;
               q_nxt.rdata[BRS_ST_START_BIT] = q_r.st == BRS_START;
               q_nxt.rdata[BRS_ST_SLEEP_BIT] = q_r.st == BRS_SLEEP;
               q_nxt.rdata[BRS_ST_BOR_BIT]   = q_r.bor;
            end
            default:          q_nxt.rdata = 8'h00;
         endcase
      end
   end

   // the only clocked process; reset loads a constant
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_r <= RST_VAL;
      end else begin
         q_r <= q_nxt;
      end
   end

   // outputs straight from the state register
   assign reg_rdata      = q_r.rdata;
   assign chip_reset     = q_r.reset;
   assign pc_load_vector = q_r.vec;
   assign port_h_dir     = q_r.h_out;
   assign port_j_dir     = q_r.j_out;
   assign timer3_control = q_r.tmr3;
   assign brownout_flag  = q_r.bor;
endmodule
`default_nettype wire

// file: src/brs_pkg.sv
// constants and types shared by the brown-out reset sequencer
package brs_pkg;
   // time base: core_clk runs at 200 MHz
   localparam int unsigned BRS_CLK_KHZ      = 200_000;
   // power-up timer delay in ms, oscillator start-up delay in oscillator periods
   localparam int unsigned BRS_PWRT_MS      = 96;
   localparam int unsigned BRS_OST_TOSC     = 1024;
   // cycle counts derived from the times above
   localparam int unsigned BRS_PWRT_CYC     = BRS_PWRT_MS * BRS_CLK_KHZ;
   localparam int unsigned BRS_OST_CYC      = BRS_OST_TOSC;
   localparam int unsigned BRS_START_CYC    = (BRS_PWRT_CYC > BRS_OST_CYC) ? BRS_PWRT_CYC : BRS_OST_CYC;
   // width of the start-up counter, holds 19.2 million
   localparam int unsigned BRS_CNT_W        = 25;

   // register offsets on the local register port
   localparam logic [3:0]  BRS_OFS_DIR_H    = 4'h0;
   localparam logic [3:0]  BRS_OFS_DIR_J    = 4'h1;
   localparam logic [3:0]  BRS_OFS_TMR3_CTL = 4'h2;
   localparam logic [3:0]  BRS_OFS_INT_STAT = 4'h3;
   localparam logic [3:0]  BRS_OFS_PFLAG1   = 4'h4;
   localparam logic [3:0]  BRS_OFS_PFLAG2   = 4'h5;
   localparam logic [3:0]  BRS_OFS_STATUS   = 4'h6;

   // reset values
   localparam logic [7:0]  BRS_RST_DIR      = 8'hFF;
   localparam logic [6:0]  BRS_RST_TMR3     = 7'h00;
   localparam logic [7:0]  BRS_RST_FLAGS    = 8'h00;

   // status register field positions
   localparam int unsigned BRS_ST_HOLD_BIT  = 0;
   localparam int unsigned BRS_ST_START_BIT = 1;
   localparam int unsigned BRS_ST_SLEEP_BIT = 2;
   localparam int unsigned BRS_ST_BOR_BIT   = 3;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      BRS_HOLD  = 4'b0001,
      BRS_START = 4'b0010,
      BRS_RUN   = 4'b0100,
      BRS_SLEEP = 4'b1000
   } brs_state_t;
endpackage

// file: src/brs_tmr_if.sv
// link between the sequencer and its start-up timer
`timescale 1ns/1ps
`default_nettype none
interface brs_tmr_if;
   logic clear;   // restart the delay from zero
   logic run;     // count while high
   logic done;    // delay has fully elapsed
   modport ctl (output clear, output run, input done);
   modport tmr (input clear, input run, output done);
endinterface
`default_nettype wire

// file: src/brs_start_timer.sv
// combined power-up and oscillator start-up delay counter
`timescale 1ns/1ps
`default_nettype none
module brs_start_timer
   import brs_pkg::*;
#(
   parameter int unsigned START_CYCLES = BRS_START_CYC
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // sequencer side
   brs_tmr_if.tmr    tmr
);
   // counter state
   typedef struct packed {
      logic [BRS_CNT_W-1:0] cnt;   // cycles elapsed
      logic                 done;  // delay complete
   } brs_tmr_st_t;

   localparam logic [BRS_CNT_W-1:0] LAST = BRS_CNT_W'(START_CYCLES - 1);

   brs_tmr_st_t q_r;    // registered state
   brs_tmr_st_t q_nxt;  // next state

   // count up to the longer of the two delays
   always_comb begin
      q_nxt = q_r;
      if (tmr.clear) begin
         // a new dip throws away the delay so far
         q_nxt.cnt  = '0;
         q_nxt.done = 1'b0;
      end else if (tmr.run && !q_r.done) begin
         q_nxt.cnt = q_r.cnt + 1'b1;
         if (q_r.cnt == LAST) begin
            q_nxt.done = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign tmr.done = q_r.done;
endmodule
`default_nettype wire

// file: dv/brs_supply_model.sv
// behavioural supply comparator and reset pin in front of the sequencer
`timescale 1ns/1ps
`default_nettype none
module brs_supply_model (
   // requests from the bench
   input  wire logic dip_req,
   input  wire logic clr_req,
   // analog side of the sequencer
   output logic      supply_low,
   output logic      master_clear_pin_n
);
   // comparator trips a little after the request, never on a clock edge
   assign #1.3 supply_low = dip_req;
   // push button is active low
   assign #0.7 master_clear_pin_n = !clr_req;
endmodule
`default_nettype wire

// file: dv/brs_seq_asserts.sv
// timing checks on the brown-out reset sequencer ports
`timescale 1ns/1ps
`default_nettype none
module brs_seq_asserts
   import brs_pkg::*;
#(
   parameter int unsigned START_CYCLES = BRS_START_CYC
) (
   // clock, reset, causes
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       supply_low,
   input wire logic       brownout_enable_bit,
   input wire logic       master_clear_pin_n,
   input wire logic       wdt_timeout,
   input wire logic       global_interrupt_disable,
   input wire logic [7:0] wake_int_set,
   // bus mode and register port
   input wire logic       ext_bus_mode,
   input wire logic [7:0] bus_dir_h,
   input wire logic [7:0] bus_dir_j,
   input wire logic [3:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // design outputs
   input wire logic       chip_reset,
   input wire logic       pc_load_vector,
   input wire logic [7:0] port_h_dir,
   input wire logic [7:0] port_j_dir,
   input wire logic [6:0] timer3_control
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // cycles spent in reset since the last cause went away
   logic [31:0] quiet_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_r <= '0;
      end else if (!chip_reset || wdt_timeout || !master_clear_pin_n || (supply_low && brownout_enable_bit)) begin
         quiet_r <= '0;
      end else begin
         quiet_r <= quiet_r + 32'd1;
      end
   end
   property p_bor_hold;
      (supply_low && brownout_enable_bit) [*4] |-> chip_reset;
   endproperty
   a_bor_hold: assert property (p_bor_hold) else $error("reset not held in brown-out");
   property p_bor_off;
      (!brownout_enable_bit && master_clear_pin_n && !wdt_timeout) [*4] |-> !$rose(chip_reset);
   endproperty
   a_bor_off: assert property (p_bor_off) else $error("reset with brown-out disabled");
   property p_start_min;
      $fell(chip_reset) |-> quiet_r >= START_CYCLES;
   endproperty
   a_start_min: assert property (p_start_min) else $error("start-up delay too short");
   property p_start_max;
      chip_reset |-> quiet_r <= START_CYCLES + 6;
   endproperty
   a_start_max: assert property (p_start_max) else $error("start-up delay too long");
   property p_dir_rst;
      chip_reset && !$past(ext_bus_mode) |-> port_h_dir == 8'hFF && port_j_dir == 8'hFF;
   endproperty
   a_dir_rst: assert property (p_dir_rst) else $error("port not input in reset");
   property p_bus_dir;
      ext_bus_mode ##1 !chip_reset |-> port_h_dir == $past(bus_dir_h) && port_j_dir == $past(bus_dir_j);
   endproperty
   a_bus_dir: assert property (p_bus_dir) else $error("bus mode direction wrong");
   property p_vector;
      pc_load_vector |-> $past(wake_int_set) != 8'h00 && !$past(global_interrupt_disable) ##1 !pc_load_vector;
   endproperty
   a_vector: assert property (p_vector) else $error("bad vector load");
   property p_tmr3_rd;
      $past(reg_rd) && $past(reg_addr) == BRS_OFS_TMR3_CTL && !chip_reset |-> reg_rdata == {1'b0, timer3_control};
   endproperty
   a_tmr3_rd: assert property (p_tmr3_rd) else $error("timer3 read wrong");
   property p_keep;
      (!chip_reset && !reg_wr) ##1 !chip_reset |-> $stable(timer3_control);
   endproperty
   a_keep: assert property (p_keep) else $error("register changed unasked");
   c_reset: cover property ($rose(chip_reset));
   c_vector: cover property (pc_load_vector);
   c_bus: cover property (ext_bus_mode && !chip_reset);
endmodule
`default_nettype wire

// file: dv/brs_sequencer_tb.sv
// self-checking bench for the brown-out reset sequencer
`timescale 1ns/1ps
`default_nettype none
module brs_sequencer_tb;
   import brs_pkg::*;
   localparam int unsigned START_CYCLES = 16;  // short delay for simulation
   // bench-driven signals
   logic            core_clk, rst_n, dip_req, clr_req, brownout_enable_bit, wdt_timeout, sleep_enter;
   logic            global_interrupt_disable, ext_bus_mode, reg_wr, reg_rd;
   logic      [7:0] wake_int_set, wake_pf1_set, wake_pf2_set, bus_dir_h, bus_dir_j, reg_wdata;
   logic      [3:0] reg_addr;
   // model and design outputs
   wire logic       supply_low, master_clear_pin_n, chip_reset, pc_load_vector, brownout_flag;
   wire logic [7:0] reg_rdata, port_h_dir, port_j_dir;
   wire logic [6:0] timer3_control;
   int              errors = 0;
   int              n_tests = 0;
   int              k;
   brs_supply_model brs_supply_model_i (.dip_req(dip_req), .clr_req(clr_req), .supply_low(supply_low),
      .master_clear_pin_n(master_clear_pin_n));
   brs_sequencer #(.START_CYCLES(START_CYCLES)) brs_sequencer_i (.core_clk(core_clk), .rst_n(rst_n),
      .supply_low(supply_low), .brownout_enable_bit(brownout_enable_bit), .master_clear_pin_n(master_clear_pin_n),
      .wdt_timeout(wdt_timeout), .sleep_enter(sleep_enter), .global_interrupt_disable(global_interrupt_disable),
      .wake_int_set(wake_int_set), .wake_pf1_set(wake_pf1_set), .wake_pf2_set(wake_pf2_set),
      .ext_bus_mode(ext_bus_mode), .bus_dir_h(bus_dir_h), .bus_dir_j(bus_dir_j), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_reset(chip_reset),
      .pc_load_vector(pc_load_vector), .port_h_dir(port_h_dir), .port_j_dir(port_j_dir),
      .timer3_control(timer3_control), .brownout_flag(brownout_flag));
   always #2.5 core_clk = ~core_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read strobe, data looked at in the following cycle only
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // bounded wait for the chip to leave reset, counts cycles
   // exp_n counts edges from the call: sync stages, hold exit and the delay
   task automatic wait_run(output int n, input int exp_n);
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (chip_reset !== 1'b0 && n < 200);
      chk(n[7:0], exp_n[7:0]);
   endtask
   task automatic print_verdict;
      if (errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // hang guard, tests take about 300 cycles
   initial begin
      #50000;
      errors++;
      print_verdict();
   end
   initial begin : main
      int n;
      core_clk = 1'b0;
      brownout_enable_bit = 1'b1;
      {rst_n, dip_req, clr_req, wdt_timeout, sleep_enter, global_interrupt_disable, ext_bus_mode, reg_wr, reg_rd} = '0;
      {wake_int_set, wake_pf1_set, wake_pf2_set, bus_dir_h, bus_dir_j, reg_wdata, reg_addr} = '0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      wait_run(n, START_CYCLES + 1);
      rd(BRS_OFS_DIR_H, 8'hFF);
      rd(BRS_OFS_DIR_J, 8'hFF);
      rd(4'hF, 8'h00);
      wr(BRS_OFS_TMR3_CTL, 8'hFF);
      rd(BRS_OFS_TMR3_CTL, 8'h7F);
      // brown-out held, then a second dip in mid start-up
      @(posedge core_clk);
      dip_req <= 1'b1;
      repeat (40) @(posedge core_clk);
      #1 chk({7'h0, chip_reset}, 8'h01);
      chk({7'h0, brownout_flag}, 8'h01);
      rd(BRS_OFS_TMR3_CTL, 8'h00);
      rd(BRS_OFS_STATUS, 8'h09);
      @(posedge core_clk);
      dip_req <= 1'b0;
      repeat (10) @(posedge core_clk);
      dip_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      dip_req <= 1'b0;
      wait_run(n, START_CYCLES + 4);
      wr(BRS_OFS_STATUS, 8'h08);
      rd(BRS_OFS_STATUS, 8'h00);
      #1 chk({7'h0, brownout_flag}, 8'h00);
      // dip ignored while brown-out is disabled
      wr(BRS_OFS_DIR_H, 8'h5A);
      brownout_enable_bit <= 1'b0;
      dip_req <= 1'b1;
      repeat (20) @(posedge core_clk);
      #1 chk({7'h0, chip_reset}, 8'h00);
      @(posedge core_clk);
      dip_req <= 1'b0;
      brownout_enable_bit <= 1'b1;
      // sleep and interrupt wake, vector allowed then blocked
      wr(BRS_OFS_TMR3_CTL, 8'h12);
      for (k = 0; k < 2; k++) begin
         @(posedge core_clk);
         global_interrupt_disable <= k[0];
         sleep_enter <= 1'b1;
         @(posedge core_clk);
         sleep_enter <= 1'b0;
         rd(BRS_OFS_STATUS, 8'h04);
         @(posedge core_clk);
         wake_int_set <= 8'h01 << k;
         wake_pf1_set <= 8'h10 << k;
         wake_pf2_set <= {k[0], 7'h00};
         @(posedge core_clk);
         wake_int_set <= 8'h00;
         wake_pf1_set <= 8'h00;
         wake_pf2_set <= 8'h00;
         #1 chk({7'h0, pc_load_vector}, {7'h0, !k[0]});
         rd(BRS_OFS_INT_STAT, {6'h0, k[0], 1'b1});
         rd(BRS_OFS_PFLAG1, {2'h0, k[0], 1'b1, 4'h0});
         rd(BRS_OFS_PFLAG2, {k[0], 7'h00});
         rd(BRS_OFS_TMR3_CTL, 8'h12);
      end
      // bus mode overrides the direction outputs only
      @(posedge core_clk);
      ext_bus_mode <= 1'b1;
      bus_dir_h <= 8'h33;
      bus_dir_j <= 8'hC3;
      repeat (2) @(posedge core_clk);
      #1 chk(port_j_dir, 8'hC3);
      chk(port_h_dir, 8'h33);
      rd(BRS_OFS_DIR_H, 8'h5A);
      @(posedge core_clk);
      ext_bus_mode <= 1'b0;
      // every reset kind: pin, watchdog, brown-out
      for (k = 0; k < 3; k++) begin
         wr(BRS_OFS_DIR_J, 8'h00);
         clr_req <= (k == 0);
         wdt_timeout <= (k == 1);
         dip_req <= (k == 2);
         @(posedge core_clk);
         wdt_timeout <= 1'b0;
         repeat (5) @(posedge core_clk);
         clr_req <= 1'b0;
         dip_req <= 1'b0;
         #1 chk(port_j_dir, 8'hFF);
         // the watchdog restart began five edges before the wait; pins and dips end at it
         wait_run(n, (k == 1) ? START_CYCLES - 4 : START_CYCLES + 4);
         rd(BRS_OFS_DIR_J, 8'hFF);
      end
      // mid-run power-on reset clears flags and the sticky cause
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(BRS_OFS_STATUS, 8'h02);
      wait_run(n, START_CYCLES - 1);
      rd(BRS_OFS_INT_STAT, 8'h00);
      rd(BRS_OFS_DIR_J, 8'hFF);
      #1 chk({7'h0, brownout_flag}, 8'h00);
      print_verdict();
   end
endmodule
bind brs_sequencer brs_seq_asserts #(.START_CYCLES(START_CYCLES)) brs_seq_asserts_i (.core_clk(core_clk),
   .rst_n(rst_n), .supply_low(supply_low), .brownout_enable_bit(brownout_enable_bit),
   .master_clear_pin_n(master_clear_pin_n), .wdt_timeout(wdt_timeout),
   .global_interrupt_disable(global_interrupt_disable), .wake_int_set(wake_int_set), .ext_bus_mode(ext_bus_mode),
   .bus_dir_h(bus_dir_h), .bus_dir_j(bus_dir_j), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .chip_reset(chip_reset), .pc_load_vector(pc_load_vector), .port_h_dir(port_h_dir),
   .port_j_dir(port_j_dir), .timer3_control(timer3_control));
`default_nettype wire
